// >>> core/sfb_pkg.sv
// Shared constants and types of the serial flash bus front end
package sfb_pkg;

  // Instruction codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE1 = 8'hC7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_DPD = 8'hB9;
  localparam logic [7:0] OP_RDPD = 8'hAB;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0B;
  localparam logic [7:0] OP_DOR = 8'h3B;
  localparam logic [7:0] OP_DIOR = 8'hBB;
  localparam logic [7:0] OP_QOR = 8'h6B;
  localparam logic [7:0] OP_QIOR = 8'hEB;
  localparam logic [7:0] OP_WQIOR = 8'hE7;
  localparam logic [7:0] OP_OQIOR = 8'hE3;

  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_TB = 5;
  localparam int ST_SEC = 6;
  localparam int ST_STATUS_LOCK_BIT_LOW = 7;
  localparam int ST_STATUS_LOCK_BIT_HIGH = 8;
  localparam int ST_QE = 9;
  localparam int ST_CMP = 14;
  localparam logic [15:0] ST_RESET = 16'h0000;
  localparam logic [15:0] ST_WR_MASK = 16'h7BFC;

  // Array geometry (address bits)
  localparam int ADDR_W = 23;
  localparam int SECTOR_AW = 12;
  localparam int BLOCK_AW = 16;

  // Phase lengths in serial clocks
  localparam logic [4:0] BYTE_EDGES = 5'h08;
  localparam logic [3:0] DUMMY_8 = 4'h8;
  localparam logic [3:0] DUMMY_4 = 4'h4;
  localparam logic [3:0] DUMMY_2 = 4'h2;

  // Timing
  localparam int CLK_NS = 5;
  localparam int PUW_NS = 1000000;
  localparam int PUW_CYC = (PUW_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_DONE, PH_IGNORE} sfb_phase_e;

  // Decoded instruction shape
  typedef struct packed {
    logic ok;
    logic quad;
    logic [2:0] alanes;
    logic [2:0] dlanes;
    logic has_addr;
    logic has_mode;
    logic [3:0] dummy;
    logic dout;
    logic din;
  } sfb_cmd_s;

  // Operation handed to the array side
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [23:0] addr;
  } sfb_op_s;

  // Whole state of the front end
  typedef struct packed {
    logic [1:0] sck_sy;
    logic sck_p;
    logic [1:0] cs_sy;
    logic cs_p;
    logic [3:0] ln_m;
    logic [3:0] ln_s;
    sfb_phase_e ph;
    logic [7:0] sh;
    logic [4:0] cnt;
    logic [7:0] opc;
    sfb_cmd_s cmd;
    logic [31:0] addr;
    logic [7:0] ob;
    logic [3:0] obits;
    logic [1:0] bytes;
    logic [15:0] wdat;
    logic [15:0] st;
    logic dpd;
    logic paused;
    logic [23:0] puw;
    logic [3:0] lo;
    logic [3:0] loe_n;
    logic pv;
    logic [7:0] pb;
    sfb_op_s op;
  } sfb_state_s;

endpackage

// >>> core/sfb_front.sv
// Serial flash bus front end: pin sampling, decode, lane control, write gating
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R1) Single lane: sample lane0 on rising clock
// (R2) Single lane: drive lane1 on falling clock
// (R3) Accept clock modes (0,0) and (1,1)
// (R4) Two-lane reads for 3Bh and BBh
// (R5) Lanes 0/1 bidirectional by instruction phase
// (R6) Four-lane reads for 6Bh, EBh, E7h, E3h
// (R7) Four-lane: write-protect and pause pins become lanes
// (R8) Four-lane needs quad lanes enable bit
// (R9) Pause only single/dual with select low
// (R10) Pause starts on pin fall or clock fall
// (R11) Pause ends on pin rise or clock fall
// (R12) Paused: output off, inputs ignored, state kept
// (R13) Host keeps select low during pause
// (R14) Supply reset disables all operations
// (R15) Power-up delay rejects write-type instructions
// (R16) Power-up leaves write latch cleared
// (R17) Write enable required before program/erase/status write
// (R18) Completion clears the write latch bit
// (R19) Protect bits make regions read-only
// (R20) Write-protect pin with lock bits gates status writes
// (R21) Deep power-down ignores all but release
// (R22) Quad lanes enable bit at status bit 9
// (R23) Write enable sets write latch bit 1
// (R24) Hardware lock with pin low refuses status write
// (R25) Select rise resets shift and decode state

// Read data buffer between user stream and serial output
module sfb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
  } sfb_fifo_s;
  sfb_fifo_s q;
  sfb_fifo_s d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // Pointer and count update; room is kept as a flop so ready is clean
  always_comb begin
    d = q;
    push = in_valid && q.room;
    pop = out_ready && (q.cnt != '0);
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = nxt(q.wp);
    end
    if (pop) begin
      d.rp = nxt(q.rp);
    end
    d.cnt = (AW + 1)'(q.cnt + {AW'(0), push} - {AW'(0), pop});
    d.room = d.cnt != (AW + 1)'(D);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.room <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.room;
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
endmodule

// Device-side bus front end
module sfb_front import sfb_pkg::*; #(
  parameter int PUW_CYCLES = PUW_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and supply reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] lane_i,
  output logic [3:0] lane_o,
  output logic [3:0] lane_oe_n,
  // Read data stream into the buffer
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [7:0] rd_data,
  // Program data out
  output logic prog_valid,
  output logic [7:0] prog_byte,
  // Array operations
  output var sfb_op_s op_start,
  input wire logic op_done,
  // Status view
  output logic [15:0] status_o,
  output logic paused_o
);
  sfb_state_s q;
  sfb_state_s d;
  logic f_valid;
  logic f_pop;
  logic [7:0] f_data;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic act;

  sfb_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(rd_valid),
    .in_ready(rd_ready),
    .in_data(rd_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // Instruction shape table
  function automatic sfb_cmd_s dec(input logic [7:0] op);
    sfb_cmd_s c;
    c = '0;
    c.ok = 1'b1;
    c.alanes = 3'h1;
    c.dlanes = 3'h1;
    case (op)
      OP_RDSR1, OP_RDSR2: c.dout = 1'b1;
      OP_READ: begin c.has_addr = 1'b1; c.dout = 1'b1; end
      OP_FREAD: begin c.has_addr = 1'b1; c.dummy = DUMMY_8; c.dout = 1'b1; end
      OP_DOR: begin c.has_addr = 1'b1; c.dummy = DUMMY_8; c.dlanes = 3'h2; c.dout = 1'b1; end // [R4]
      OP_DIOR: begin // [R4] [R5]
        c.has_addr = 1'b1; c.has_mode = 1'b1; c.alanes = 3'h2; c.dlanes = 3'h2; c.dout = 1'b1;
      end
      OP_QOR: begin // [R6]
        c.quad = 1'b1; c.has_addr = 1'b1; c.dummy = DUMMY_8; c.dlanes = 3'h4; c.dout = 1'b1;
      end
      OP_QIOR, OP_WQIOR, OP_OQIOR: begin // [R6] [R7]
        c.quad = 1'b1; c.has_addr = 1'b1; c.has_mode = 1'b1; c.alanes = 3'h4; c.dlanes = 3'h4;
        c.dout = 1'b1;
        c.dummy = (op == OP_QIOR) ? DUMMY_4 : (op == OP_WQIOR) ? DUMMY_2 : 4'h0;
      end
      OP_PP: begin c.has_addr = 1'b1; c.din = 1'b1; end
      OP_SE, OP_BE32, OP_BE64: c.has_addr = 1'b1;
      OP_WRSR: c.din = 1'b1;
      OP_WREN, OP_WRDI, OP_CE1, OP_CE2, OP_DPD, OP_RDPD: c.ok = 1'b1;
      default: c.ok = 1'b0;
    endcase
    return c;
  endfunction

  // Shift in one edge worth of bits from the active lanes
  function automatic logic [31:0] shin(input logic [31:0] v, input logic [2:0] w, input logic [3:0] l);
    case (w)
      3'h4: return {v[27:0], l}; // [R7]
      3'h2: return {v[29:0], l[1:0]}; // [R5]
      default: return {v[30:0], l[0]}; // [R1]
    endcase
  endfunction

  // Clock edges spent on address plus mode bits
  function automatic logic [4:0] aedges(input sfb_cmd_s c);
    if (c.alanes == 3'h4) begin
      return c.has_mode ? 5'h08 : 5'h06;
    end else if (c.alanes == 3'h2) begin
      return c.has_mode ? 5'h10 : 5'h0C;
    end
    return 5'h18;
  endfunction

  // True if the address falls in the read-only region
  function automatic logic prot(input logic [23:0] a, input logic [15:0] s);
    logic [4:0] sz;
    logic [ADDR_W-1:0] m;
    logic hit;
    sz = 5'(int'(s[ST_SEC] ? SECTOR_AW : BLOCK_AW) + int'(s[ST_BP_LO+:3]) - 1);
    m = (sz >= 5'(ADDR_W)) ? '0 : ~((ADDR_W'(1) << sz) - ADDR_W'(1));
    hit = (s[ST_BP_LO+:3] != 3'h0) &&
          (s[ST_TB] ? ((a[ADDR_W-1:0] & m) == '0) : ((a[ADDR_W-1:0] & m) == m)); // [R19]
    return hit ^ s[ST_CMP];
  endfunction

  // Edge finding on synchronised pins; works for either clock idle level
  assign sck_rise = q.sck_sy[1] && !q.sck_p; // [R3]
  assign sck_fall = !q.sck_sy[1] && q.sck_p; // [R3]
  assign cs_rise = q.cs_sy[1] && !q.cs_p;
  assign act = !q.cs_sy[1] && !q.paused; // [R12]

  always_comb begin
    logic wr_ok;
    logic [7:0] b;
    logic [3:0] nb;
    logic [2:0] w;
    sfb_cmd_s c;
    wr_ok = 1'b0;
    b = 8'h00;
    nb = 4'h0;
    w = q.cmd.dlanes;
    c = '0;
    d = q;
    f_pop = 1'b0;
    // Two-stage synchronisers
    d.sck_sy = {q.sck_sy[0], sclk};
    d.sck_p = q.sck_sy[1];
    d.cs_sy = {q.cs_sy[0], cs_n};
    d.cs_p = q.cs_sy[1];
    d.ln_m = lane_i;
    d.ln_s = q.ln_m;
    d.pv = 1'b0;
    d.op.valid = 1'b0;
    if (q.puw != '0) begin
      d.puw = q.puw - 24'h1; // [R15]
    end
    // Pause follows the pin only while the clock is low, so a change seen with
    // the clock high waits for the next falling edge
    if (q.cs_sy[1] || q.st[ST_QE] || q.cmd.quad) begin
      d.paused = 1'b0; // [R9]
    end else if (!q.sck_sy[1]) begin
      d.paused = !q.ln_s[3]; // [R10] [R11]
    end
    if (cs_rise) begin
      // Run the completed instruction, then start clean
      wr_ok = q.st[ST_WEL] && (q.puw == '0); // [R15] [R17]
      case (q.opc)
        OP_WREN: if (q.ph == PH_DONE && q.puw == '0) d.st[ST_WEL] = 1'b1; // [R23] [R15]
        OP_WRDI: if (q.ph == PH_DONE) d.st[ST_WEL] = 1'b0;
        OP_DPD: if (q.ph == PH_DONE) d.dpd = 1'b1;
        OP_RDPD: if (q.ph == PH_DONE) d.dpd = 1'b0; // [R21]
        OP_WRSR: begin
          // Lock bits: hardware lock honours the pin only while it is not a lane
          if (q.ph == PH_DIN && q.bytes != 2'h0 && wr_ok && !q.st[ST_STATUS_LOCK_BIT_HIGH] &&
              !(q.st[ST_STATUS_LOCK_BIT_LOW] && !q.st[ST_QE] && !q.ln_s[2])) begin // [R20] [R24] [R17]
            b = 8'h00;
            d.st = (q.st & ~ST_WR_MASK) |
                   (((q.bytes == 2'h1) ? {q.st[15:8], q.wdat[7:0]} : q.wdat) & ST_WR_MASK);
            d.st[ST_BUSY] = 1'b1;
            d.op = '{valid: 1'b1, code: q.opc, addr: 24'h000000};
          end
        end
        OP_PP, OP_SE, OP_BE32, OP_BE64: begin
          if (((q.ph == PH_DIN && q.bytes != 2'h0) || (q.ph == PH_DONE && q.opc != OP_PP)) &&
              wr_ok && !prot(q.addr[23:0], q.st)) begin // [R17] [R19]
            d.st[ST_BUSY] = 1'b1;
            d.op = '{valid: 1'b1, code: q.opc, addr: q.addr[23:0]};
          end
        end
        OP_CE1, OP_CE2: begin
          if (q.ph == PH_DONE && wr_ok && q.st[ST_BP_LO+:3] == 3'h0 && !q.st[ST_CMP]) begin // [R19]
            d.st[ST_BUSY] = 1'b1;
            d.op = '{valid: 1'b1, code: q.opc, addr: 24'h000000};
          end
        end
        default: d.st = q.st;
      endcase
    end
    if (q.cs_sy[1]) begin
      // Deselected: decode state held at its start point
      d.ph = PH_CMD; // [R25]
      d.cnt = '0;
      d.bytes = '0;
      d.obits = '0;
      d.cmd = '0;
    end else if (act && sck_rise) begin
      case (q.ph)
        PH_CMD: begin
          d.sh = 8'(shin({24'h0, q.sh}, 3'h1, q.ln_s)); // [R1]
          d.cnt = q.cnt + 5'h1;
          if (q.cnt == BYTE_EDGES - 5'h1) begin
            c = dec(d.sh);
            d.opc = d.sh;
            d.cmd = c;
            d.cnt = '0;
            if (!c.ok || (q.dpd && d.sh != OP_RDPD) || // [R21]
                (q.st[ST_BUSY] && d.sh != OP_RDSR1 && d.sh != OP_RDSR2) ||
                (c.quad && !q.st[ST_QE])) begin // [R8]
              d.ph = PH_IGNORE;
            end else if (c.has_addr) begin
              d.ph = PH_ADDR;
            end else if (c.din) begin
              d.ph = PH_DIN;
            end else if (c.dout) begin
              d.ph = PH_DOUT;
            end else begin
              d.ph = PH_DONE;
            end
          end
        end
        PH_ADDR: begin
          d.addr = shin(q.addr, q.cmd.alanes, q.ln_s); // [R5] [R7]
          d.cnt = q.cnt + 5'h1;
          if (q.cnt == aedges(q.cmd) - 5'h1) begin
            d.cnt = '0;
            if (q.cmd.has_mode) begin
              d.addr = {8'h00, d.addr[31:8]};
            end
            d.ph = q.cmd.din ? PH_DIN : !q.cmd.dout ? PH_DONE : (q.cmd.dummy != 4'h0) ? PH_DUMMY : PH_DOUT;
          end
        end
        PH_DUMMY: begin
          d.cnt = q.cnt + 5'h1;
          if (q.cnt == {1'b0, q.cmd.dummy} - 5'h1) begin
            d.cnt = '0;
            d.ph = PH_DOUT;
          end
        end
        PH_DIN: begin
          d.sh = 8'(shin({24'h0, q.sh}, 3'h1, q.ln_s)); // [R1]
          d.cnt = q.cnt + 5'h1;
          if (q.cnt == BYTE_EDGES - 5'h1) begin
            d.cnt = '0;
            d.pv = q.opc == OP_PP;
            d.pb = d.sh;
            if (q.bytes == 2'h0) begin
              d.wdat[7:0] = d.sh;
            end else if (q.bytes == 2'h1) begin
              d.wdat[15:8] = d.sh;
            end
            if (q.bytes != 2'h3) begin
              d.bytes = q.bytes + 2'h1;
            end
          end
        end
        default: d.cnt = q.cnt;
      endcase
    end else if (act && sck_fall && q.ph == PH_DOUT) begin
      // Output changes on falling edges; empty buffer reads as all ones
      if (q.obits == 4'h0) begin
        if (q.opc == OP_RDSR1) begin
          b = q.st[7:0];
        end else if (q.opc == OP_RDSR2) begin
          b = q.st[15:8];
        end else begin
          b = f_valid ? f_data : 8'hFF;
          f_pop = 1'b1;
        end
        nb = 4'h8;
      end else begin
        b = q.ob;
        nb = q.obits;
      end
      if (w == 3'h4) begin
        d.lo = b[7:4]; // [R7]
      end else if (w == 3'h2) begin
        d.lo = {2'b00, b[7:6]}; // [R5]
      end else begin
        d.lo = {2'b00, b[7], 1'b0}; // [R2]
      end
      d.ob = 8'(b << w);
      d.obits = nb - {1'b0, w};
    end
    // Completion of the array operation
    if (op_done && q.st[ST_BUSY]) begin
      d.st[ST_BUSY] = 1'b0;
      d.st[ST_WEL] = 1'b0; // [R18]
    end
    // Lane drivers: enable low only in the output phase and never while paused
    if (!q.cs_sy[1] && !d.paused && d.ph == PH_DOUT) begin // [R12]
      d.loe_n = (d.cmd.dlanes == 3'h4) ? 4'h0 : (d.cmd.dlanes == 3'h2) ? 4'hC : 4'hD;
    end else begin
      d.loe_n = 4'hF;
    end
  end

  // Supply reset clears everything and restarts the power-up delay
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0; // [R14]
      q.cs_sy <= 2'b11;
      q.cs_p <= 1'b1;
      q.st <= ST_RESET; // [R16]
      q.puw <= 24'(PUW_CYCLES); // [R15]
      q.loe_n <= 4'hF;
    end else begin
      q <= d;
    end
  end

  assign lane_o = q.lo;
  assign lane_oe_n = q.loe_n;
  assign prog_valid = q.pv;
  assign prog_byte = q.pb;
  assign op_start = q.op;
  assign status_o = q.st;
  assign paused_o = q.paused;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_r1_shift;
    (act && sck_rise && q.ph == PH_CMD) |=> (q.sh[0] == $past(q.ln_s[0]));
  endproperty
  a_r1_shift: assert property (p_r1_shift) else $error("command bit not taken from lane0"); // [R1]

  property p_r2_fall;
    $changed(q.lo) |-> $past(sck_fall);
  endproperty
  a_r2_fall: assert property (p_r2_fall) else $error("output changed off a falling edge"); // [R2]

  property p_r8_quad;
    (q.cmd.quad && !q.st[ST_QE]) |-> (q.ph != PH_DOUT && q.loe_n == 4'hF);
  endproperty
  a_r8_quad: assert property (p_r8_quad) else $error("quad read ran without enable bit"); // [R8]

  property p_r12_pause;
    q.paused |-> (q.loe_n == 4'hF);
  endproperty
  a_r12_pause: assert property (p_r12_pause) else $error("lanes driven while paused"); // [R12]

  property p_r9_nopause;
    (q.st[ST_QE] || q.cs_sy[1]) |=> !q.paused;
  endproperty
  a_r9_nopause: assert property (p_r9_nopause) else $error("pause outside single or dual"); // [R9]

  property p_r15_puw;
    (q.puw != '0) |-> !q.st[ST_WEL] && !q.op.valid;
  endproperty
  a_r15_puw: assert property (p_r15_puw) else $error("write accepted in power-up delay"); // [R15]

  property p_r18_done;
    (op_done && q.st[ST_BUSY]) |=> (!q.st[ST_WEL] && !q.st[ST_BUSY]);
  endproperty
  a_r18_done: assert property (p_r18_done) else $error("write latch kept after completion"); // [R18]

  property p_r21_dpd;
    (q.dpd && cs_rise && q.opc != OP_RDPD) |=> q.dpd;
  endproperty
  a_r21_dpd: assert property (p_r21_dpd) else $error("left deep power-down wrongly"); // [R21]

  property p_r25_cs;
    cs_rise |=> (q.ph == PH_CMD && q.cnt == 5'h00) [*2];
  endproperty
  a_r25_cs: assert property (p_r25_cs) else $error("decode not restarted on select rise"); // [R25]

  property p_r24_wp;
    (cs_rise && q.opc == OP_WRSR && q.st[ST_STATUS_LOCK_BIT_LOW] && !q.st[ST_QE] && !q.ln_s[2]) |=> $stable(q.st[15:2]);
  endproperty
  a_r24_wp: assert property (p_r24_wp) else $error("status written with pin lock on"); // [R24]

  property p_r23_wel;
    (cs_rise && q.opc == OP_WREN && q.ph == PH_DONE && q.puw == '0) |=> q.st[ST_WEL];
  endproperty
  a_r23_wel: assert property (p_r23_wel) else $error("write enable did not set latch"); // [R23]
endmodule
`default_nettype wire

// >>> dv/sfb_host.sv
// Behavioural bus host that drives clock, select and lanes
`timescale 1ns/1ps
`default_nettype none
module sfb_host (
  // Host pins
  output logic sclk,
  output logic cs_n,
  // Resolved lane levels
  output logic [3:0] lane_i,
  // Device drive
  input wire logic [3:0] lane_o,
  input wire logic [3:0] lane_oe_n
);
  logic [3:0] he = 4'hC;
  logic d0 = 1'b1;
  logic wp = 1'b1;
  logic hold = 1'b1;
  logic mode = 1'b0;
  int half = 24;

  // Pulled-up lanes: a released line goes high, it never keeps its last value
  assign lane_i = (~lane_oe_n & lane_o) | (lane_oe_n & ((he & {hold, wp, 1'b1, d0}) | ~he));

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end

  // Select falls with the clock parked at the mode's idle level
  task automatic start(input logic m);
    mode = m;
    sclk = m;
    he = 4'hD;
    #(half);
    cs_n = 1'b0;
    #(half);
  endtask

  // Data changes with the clock low and is taken on the rise
  task automatic shift(input int n, input int w, input logic [31:0] dout, output logic [31:0] din);
    din = 32'h0;
    he = (w == 4) ? 4'h0 : (w == 2) ? 4'hC : 4'hD;
    for (int i = n - 1; i >= 0; i = i - w) begin
      sclk = 1'b0;
      d0 = dout[i];
      #(half);
      din = (w == 1) ? {din[30:0], lane_i[1]} : (w == 2) ? {din[29:0], lane_i[1:0]} : {din[27:0], lane_i};
      sclk = 1'b1;
      #(half);
    end
  endtask

  // Select rises with the clock back at idle; never used inside a pause
  task automatic stop();
    #(half);
    if (!mode) sclk = 1'b0;
    #(half);
    cs_n = 1'b1;
    he = 4'hC;
    #(6 * half);
  endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the serial flash bus front end
`timescale 1ns/1ps
`default_nettype none
module testbench import sfb_pkg::*; ();
  localparam int PUW = 300;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sclk;
  logic cs_n;
  logic [3:0] lane_i;
  logic [3:0] lane_o;
  logic [3:0] lane_oe_n;
  logic rd_valid = 1'b0;
  logic rd_ready;
  logic [7:0] rd_data = 8'h00;
  logic prog_valid;
  logic [7:0] prog_byte;
  sfb_op_s op_start;
  sfb_op_s op_last;
  logic op_done = 1'b0;
  logic [15:0] status_o;
  logic paused_o;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'h7D411EC1;
  int st_m = 0;
  int n_op = 0;
  int op_cnt = 0;
  logic [7:0] fq[$];
  logic [7:0] pq[$];
  logic [31:0] v;
  logic [31:0] a;

  initial begin
    forever #2.5 clk = ~clk;
  end

  sfb_front #(.PUW_CYCLES(PUW), .FIFO_DEPTH(8)) u_sfb_front (.clk(clk), .reset(reset), .sclk(sclk),
    .cs_n(cs_n), .lane_i(lane_i), .lane_o(lane_o), .lane_oe_n(lane_oe_n), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .prog_valid(prog_valid), .prog_byte(prog_byte),
    .op_start(op_start), .op_done(op_done), .status_o(status_o), .paused_o(paused_o));
  sfb_host u_sfb_host (.sclk(sclk), .cs_n(cs_n), .lane_i(lane_i), .lane_o(lane_o), .lane_oe_n(lane_oe_n));

  // Capture one-cycle pulses mid-cycle, where they are settled, so later checks cannot miss them
  always @(negedge clk) begin
    if (prog_valid === 1'b1) pq.push_back(prog_byte);
    if (op_start.valid === 1'b1) begin
      op_cnt++;
      op_last = op_start;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole frame: opcode and up to 32 argument bits on lane0
  task automatic cmd(input logic [7:0] op, input int nb = 0, input logic [31:0] arg = 0, input logic m = 0);
    logic [31:0] x;
    u_sfb_host.start(m);
    u_sfb_host.shift(8, 1, {24'h0, op}, x);
    if (nb > 0) u_sfb_host.shift(nb, 1, arg, x);
    u_sfb_host.stop();
  endtask

  // Read frame: address and dummy bits on lane0, then bytes on w lanes
  task automatic rd(input logic [7:0] op, input int ab, input int w, input int nby, input logic [3:0] oe,
                    output logic [31:0] d, input logic m = 0);
    logic [31:0] x;
    u_sfb_host.start(m);
    u_sfb_host.shift(8, 1, {24'h0, op}, x);
    if (ab > 0) u_sfb_host.shift(ab, 1, 32'h0, x);
    u_sfb_host.shift(nby * 8, w, 32'h0, d);
    chk("lane_oe_n", lane_oe_n, oe);
    u_sfb_host.stop();
  endtask

  task automatic done();
    @(negedge clk) op_done = 1'b1;
    @(negedge clk) op_done = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  initial begin
    repeat (9) @(negedge clk);
    // Held in reset: idle pins, write latch clear
    chk("reset", {paused_o, rd_ready, lane_oe_n, status_o}, 22'h1F0000);
    @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    cmd(OP_WREN);
    chk("wel_early", status_o, st_m);
    repeat (PUW) @(negedge clk);
    // Fill the read buffer until it refuses, nothing drains it
    for (int i = 0; i < 12; i++) begin
      rd_data = 8'($random(seed));
      rd_valid = 1'b1;
      if (rd_ready === 1'b1) fq.push_back(rd_data);
      @(negedge clk);
    end
    rd_valid = 1'b0;
    chk("fill", fq.size(), 8);
    // Mode 3: no falling edge at select rise, so no extra byte leaves the buffer
    rd(OP_READ, 24, 1, 4, 4'hD, v, 1);
    chk("read", v, {fq[0], fq[1], fq[2], fq[3]});
    rd(OP_DOR, 32, 2, 4, 4'hC, v);
    chk("dual", v, {fq[4], fq[5], fq[6], fq[7]});
    rd(OP_QOR, 32, 4, 1, 4'hF, v);
    // Both clock modes; write enable from mode 3
    cmd(OP_WREN, 0, 0, 1);
    st_m = 2;
    chk("wel", status_o, st_m);
    rd(OP_RDSR1, 0, 1, 1, 4'hD, v, 1);
    chk("sr1_m3", v, st_m & 8'hFF);
    rd(OP_RDSR2, 0, 1, 1, 4'hD, v);
    chk("sr2_m0", v, st_m >> 8);
    // Program refused without the latch, then accepted after write enable
    cmd(OP_WRDI);
    st_m = 0;
    a = 32'($random(seed)) & 32'h7FFFFFFF;
    cmd(OP_PP, 32, a);
    chk("pp_nolatch", op_cnt, n_op);
    cmd(OP_WREN);
    pq.delete();
    cmd(OP_PP, 32, a);
    n_op++;
    st_m = 3;
    chk("prog_n", pq.size(), 1);
    chk("prog_byte", pq[0], a[7:0]);
    chk("op", {op_last.code, op_last.addr}, {OP_PP, a[31:8]});
    rd(OP_RDSR1, 0, 1, 1, 4'hD, v);
    chk("busy", v, st_m);
    done();
    st_m = 0;
    chk("wel_clr", status_o, st_m);
    // Quad lanes enable, then a four-lane read from the empty buffer
    cmd(OP_WREN);
    cmd(OP_WRSR, 16, 32'h0002);
    n_op++;
    done();
    st_m = 16'h0200;
    chk("qe", status_o, st_m);
    rd(OP_QOR, 32, 4, 1, 4'h0, v);
    chk("quad", v, 8'hFF);
    // Fast read with dummy clocks takes one fresh byte from the buffer
    fq.delete();
    rd_data = 8'($random(seed));
    rd_valid = 1'b1;
    fq.push_back(rd_data);
    @(negedge clk) rd_valid = 1'b0;
    rd(OP_FREAD, 32, 1, 1, 4'hD, v, 1);
    chk("fread", v, fq[0]);
    // Hardware lock with the protect pin low refuses status writes
    cmd(OP_WREN);
    cmd(OP_WRSR, 16, 32'h8000);
    n_op++;
    done();
    u_sfb_host.wp = 1'b0;
    cmd(OP_WREN);
    cmd(OP_WRSR, 16, 32'h0000);
    st_m = 16'h0082;
    chk("locked", status_o, st_m);
    chk("locked_op", op_cnt, n_op);
    u_sfb_host.wp = 1'b1;
    // Slow host pauses a status read in its output phase
    u_sfb_host.half = 40;
    u_sfb_host.start(0);
    u_sfb_host.shift(8, 1, {24'h0, OP_RDSR1}, a);
    u_sfb_host.shift(4, 1, 32'h0, v);
    u_sfb_host.hold = 1'b0;
    repeat (10) @(negedge clk);
    chk("pause_wait", paused_o, 1'b0);
    u_sfb_host.sclk = 1'b0;
    repeat (10) @(negedge clk);
    chk("paused", {paused_o, lane_oe_n}, 5'h1F);
    u_sfb_host.shift(3, 1, 32'h7, a);
    u_sfb_host.sclk = 1'b0;
    repeat (10) @(negedge clk);
    u_sfb_host.hold = 1'b1;
    repeat (10) @(negedge clk);
    chk("resumed", paused_o, 1'b0);
    u_sfb_host.shift(4, 1, 32'h0, a);
    chk("sr_pause", {v[3:0], a[3:0]}, st_m & 8'hFF);
    u_sfb_host.stop();
    u_sfb_host.half = 24;
    // Deep power-down ignores write enable; a cut frame leaves no trace
    cmd(OP_WRDI);
    st_m = 16'h0080;
    cmd(OP_DPD);
    cmd(OP_WREN);
    chk("dpd", status_o, st_m);
    cmd(OP_RDPD);
    u_sfb_host.start(1);
    u_sfb_host.shift(5, 1, 32'h0, v);
    u_sfb_host.stop();
    cmd(OP_WREN, 0, 0, 1);
    st_m = 16'h0082;
    chk("wake", status_o, st_m);
    // Top 4 kB sector read-only: erase there and chip erase refused, bottom allowed
    cmd(OP_WRSR, 16, 32'h4400);
    n_op++;
    done();
    st_m = 16'h0044;
    chk("prot_set", status_o, st_m);
    cmd(OP_WREN);
    cmd(OP_SE, 24, 32'h7FF000);
    cmd(OP_CE1);
    chk("prot_op", op_cnt, n_op);
    cmd(OP_SE, 24, 32'h001000);
    n_op++;
    chk("se_op", {op_last.code, op_last.addr}, {OP_SE, 24'h001000});
    done();
    chk("se_done", status_o, st_m);
    chk("op_total", op_cnt, n_op);
    summarize();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
